/* inc/ipt_pkg.sv */
// Operation
// - field codes 001..111 give priority equal to value; 111 is level 7.
// - field code 001 gives priority 1, the lowest enabled level.
// - field code 000 disables the source; it never raises a request.
// - unimplemented bits read zero and ignore writes.
// - clock timestamp priority sits in bits 10-8, read and write.
// - serial6 rx priority in bits 10-8, serial6 tx in bits 14-12.
// - test port priority in bits 6-4; bits 15-7 unimplemented.
// - serial6 error priority in bits 2-0; bit 3 unimplemented.
// - test register bits 11-8 show current cpu level 0..15.
// - every implemented priority field resets to 100, level 4.
package ipt_pkg;
    // ==========================================================
    // sizes
    localparam int NUM_SRC  = 13;
    localparam int NUM_PRIO = 5;
    localparam int PW       = 3;
    // ==========================================================
    // byte offsets on the bus
    localparam logic [7:0] OFS_PRIORITY_CFG_TIMERS_DISPLAY       = 8'h00;
    localparam logic [7:0] OFS_PRIORITY_CFG_OSC_SELFTUNE         = 8'h04;
    localparam logic [7:0] OFS_PRIORITY_CFG_SERIAL5_RX_TIMESTAMP = 8'h08;
    localparam logic [7:0] OFS_PRIORITY_CFG_SERIAL5_SERIAL6      = 8'h0C;
    localparam logic [7:0] OFS_PRIORITY_CFG_TESTPORT_SERIAL6_ERR = 8'h10;
    localparam logic [7:0] OFS_INTERRUPT_TEST_STATUS             = 8'h14;
    // ==========================================================
    // implemented bits and reset pattern of priority registers
    localparam logic [15:0] PRIO_MASK [NUM_PRIO] =
        '{16'h0777, 16'h0700, 16'h7770, 16'h7777, 16'h0077};
    localparam logic [15:0] PRIO_RST_PAT = 16'h4444;
    localparam logic [2:0]  PRIO_OFF     = 3'h0;
    localparam logic [2:0]  PRIO_TOP     = 3'h7;
    localparam logic [2:0]  PRIO_LOW     = 3'h1;
    // ==========================================================
    // source placement: register index and field lsb
    localparam int SRC_REG [NUM_SRC] =
        '{0, 0, 0, 1, 2, 2, 2, 3, 3, 3, 3, 4, 4};
    localparam int SRC_LSB [NUM_SRC] =
        '{8, 4, 0, 8, 12, 8, 4, 12, 8, 4, 0, 4, 0};
    // ==========================================================
    // test register layout
    localparam int          TST_PEND_BIT = 15;
    localparam int          TST_HOLD_BIT = 13;
    localparam int          TST_LVL_LSB  = 8;
    localparam logic [15:0] TST_MASK     = 16'hAF7F;
    localparam logic        HOLD_RST     = 1'b0;
    // vector number of source 0; value is arbitrary
    localparam logic [6:0]  VEC_BASE     = 7'h08;
    // ==========================================================
    // arbitration winner
    typedef struct packed {
        logic       valid;
        logic [2:0] prio;
        logic [3:0] idx;
    } ipt_win_type;
endpackage : ipt_pkg

/* rtl/ipt_prio_reg.sv */
`timescale 1ns/10ps
`default_nettype none
module ipt_prio_reg
    import ipt_pkg::*;
#(
    parameter logic [15:0] MASK = 16'h0000
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // write port
    input  wire logic        wr_en_i,
    input  wire logic [1:0]  sel_i,
    input  wire logic [15:0] dat_i,
    // contents
    output logic [15:0]      q_o
);
    logic [15:0] wm;

    // byte lanes limited to implemented bits
    assign wm = MASK & {{8{sel_i[1]}}, {8{sel_i[0]}}};

    // ==========================================================
    // storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= PRIO_RST_PAT & MASK;
        end else if (wr_en_i) begin
            q_o <= (q_o & ~wm) | (dat_i & wm);
        end
    end
endmodule : ipt_prio_reg
`default_nettype wire

/* rtl/ipt_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
module ipt_arbiter
    import ipt_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // sources
    input  wire logic [NUM_SRC-1:0]    req_i,
    input  wire logic [NUM_SRC*PW-1:0] prio_i,
    // registered winner
    output ipt_win_type                win_o
);
    ipt_win_type      best;
    logic [NUM_SRC-1:0] top_req;
    logic [NUM_SRC-1:0] hi_req;

    // ==========================================================
    // highest field wins, ties go to lowest index
    always_comb begin
        best = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req_i[i] && prio_i[i*PW +: PW] != PRIO_OFF &&
                prio_i[i*PW +: PW] > best.prio) begin
                best.valid = 1'b1;
                best.prio  = prio_i[i*PW +: PW];
                best.idx   = 4'(i);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_o <= '0;
        end else begin
            win_o <= best;
        end
    end

    // helper flags per source for checking
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_chk
        assign top_req[g] = req_i[g] && prio_i[g*PW +: PW] == PRIO_TOP;
        assign hi_req[g]  = req_i[g] && prio_i[g*PW +: PW] > PRIO_LOW;
    end

    a_top_level_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        |top_req |=> win_o.valid && win_o.prio == 3'h7)
        else $error("level 7 request did not win");
    a_low_level_one: assert property (@(posedge clk_i) disable iff (rst_i)
        win_o.prio == 3'h1 |-> !$past(|hi_req))
        else $error("level 1 won over a higher request");
    a_disabled_silent: assert property (@(posedge clk_i) disable iff (rst_i)
        win_o.valid |-> win_o.prio != 3'h0)
        else $error("disabled source won");
endmodule : ipt_arbiter
`default_nettype wire

/* rtl/ipt_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module ipt_regs
    import ipt_pkg::*;
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // peripheral request lines, flag and enable already applied
    input  wire logic [NUM_SRC-1:0] src_req_i,
    // processor core side
    input  wire logic [3:0]         cpu_level_i,
    input  wire logic               cpu_ack_i,
    output logic                    cpu_irq_o,
    output logic      [2:0]         cpu_irq_prio_o,
    output logic      [6:0]         cpu_irq_vec_o
);
    // ==========================================================
    // declarations
    logic                  ack_r;
    logic                  req_live;
    logic                  wr_ok;
    logic [NUM_PRIO-1:0]   prio_wr;
    logic                  tst_wr;
    logic                  hit;
    logic [15:0]           rd_word;
    logic [15:0]           rd_mask;
    logic [15:0]           cfg_q [NUM_PRIO];
    logic [NUM_SRC*PW-1:0] fields;
    ipt_win_type           win;
    logic                  pending_r;
    logic                  pending_nxt;
    logic                  hold_r;
    logic [3:0]            level_r;
    logic [6:0]            ack_vec_r;
    logic [6:0]            top_vec_r;
    logic [6:0]            win_vec;
    logic [6:0]            shown_vec;
    logic [15:0]           tst_word;

    // ==========================================================
    // bus handshake
    // a request is live while cyc and stb are both high
    assign req_live = wb_cyc_i && wb_stb_i;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req_live && !ack_r;
        end
    end

    assign wb_ack_o = ack_r;

    // a write lands on the edge where ack is seen
    assign wr_ok = req_live && wb_we_i && ack_r;

    // ==========================================================
    // address decode
    always_comb begin
        prio_wr = '0;
        tst_wr  = 1'b0;
        hit     = 1'b1;
        case (wb_adr_i)
            OFS_PRIORITY_CFG_TIMERS_DISPLAY: begin
                prio_wr[0] = wr_ok;
            end
            OFS_PRIORITY_CFG_OSC_SELFTUNE: begin
                prio_wr[1] = wr_ok;
            end
            OFS_PRIORITY_CFG_SERIAL5_RX_TIMESTAMP: begin
                prio_wr[2] = wr_ok;
            end
            OFS_PRIORITY_CFG_SERIAL5_SERIAL6: begin
                prio_wr[3] = wr_ok;
            end
            OFS_PRIORITY_CFG_TESTPORT_SERIAL6_ERR: begin
                prio_wr[4] = wr_ok;
            end
            OFS_INTERRUPT_TEST_STATUS: begin
                tst_wr = wr_ok;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // priority registers, one per generate entry
    for (genvar r = 0; r < NUM_PRIO; r++) begin : g_prio
        ipt_prio_reg #(
            .MASK    (PRIO_MASK[r])
        ) u_reg (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .wr_en_i (prio_wr[r]),
            .sel_i   (wb_sel_i[1:0]),
            .dat_i   (wb_dat_i[15:0]),
            .q_o     (cfg_q[r])
        );
    end

    // gather each source's field into one flat vector
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_field
        assign fields[s*PW +: PW] =
            cfg_q[SRC_REG[s]][SRC_LSB[s] +: PW];
    end

    // ==========================================================
    // arbitration among requesting sources
    ipt_arbiter u_arb (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .req_i  (src_req_i),
        .prio_i (fields),
        .win_o  (win)
    );

    assign win_vec = VEC_BASE + 7'(win.idx);

    // ==========================================================
    // request toward the core
    // raised while the winner outranks the cpu level; an ack
    // withdraws it until the winner is judged again
    always_comb begin
        pending_nxt = win.valid && ({1'b0, win.prio} > cpu_level_i);
        if (cpu_ack_i) begin
            pending_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_r <= 1'b0;
        end else begin
            pending_r <= pending_nxt;
        end
    end

    // priority and vector presented with the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_irq_prio_o <= 3'h0;
            cpu_irq_vec_o  <= 7'h00;
        end else begin
            cpu_irq_prio_o <= win.prio;
            cpu_irq_vec_o  <= win_vec;
        end
    end

    assign cpu_irq_o = pending_r;

    // ==========================================================
    // test register state
    // capture select, the only writable bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r <= HOLD_RST;
        end else if (tst_wr && wb_sel_i[1]) begin
            hold_r <= wb_dat_i[TST_HOLD_BIT];
        end
    end

    // mirror of the cpu level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_r <= 4'h0;
        end else begin
            level_r <= cpu_level_i;
        end
    end

    // vector of the last acknowledged request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_vec_r <= 7'h00;
        end else if (cpu_ack_i && pending_r) begin
            ack_vec_r <= cpu_irq_vec_o;
        end
    end

    // vector of the highest pending request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            top_vec_r <= 7'h00;
        end else if (win.valid) begin
            top_vec_r <= win_vec;
        end else begin
            top_vec_r <= 7'h00;
        end
    end

    assign shown_vec = hold_r ? top_vec_r : ack_vec_r;

    // assembled test word, reserved bits tied low
    always_comb begin
        tst_word                = 16'h0000;
        tst_word[TST_PEND_BIT]  = pending_r;
        tst_word[TST_HOLD_BIT]  = hold_r;
        tst_word[TST_LVL_LSB +: 4] = level_r;
        tst_word[6:0]           = shown_vec;
    end

    // ==========================================================
    // read path
    always_comb begin
        rd_word = 16'h0000;
        rd_mask = 16'h0000;
        case (wb_adr_i)
            OFS_PRIORITY_CFG_TIMERS_DISPLAY: begin
                rd_word = cfg_q[0];
                rd_mask = PRIO_MASK[0];
            end
            OFS_PRIORITY_CFG_OSC_SELFTUNE: begin
                rd_word = cfg_q[1];
                rd_mask = PRIO_MASK[1];
            end
            OFS_PRIORITY_CFG_SERIAL5_RX_TIMESTAMP: begin
                rd_word = cfg_q[2];
                rd_mask = PRIO_MASK[2];
            end
            OFS_PRIORITY_CFG_SERIAL5_SERIAL6: begin
                rd_word = cfg_q[3];
                rd_mask = PRIO_MASK[3];
            end
            OFS_PRIORITY_CFG_TESTPORT_SERIAL6_ERR: begin
                rd_word = cfg_q[4];
                rd_mask = PRIO_MASK[4];
            end
            OFS_INTERRUPT_TEST_STATUS: begin
                rd_word = tst_word;
                rd_mask = TST_MASK;
            end
            default: begin
                rd_word = 16'h0000;
                rd_mask = 16'h0000;
            end
        endcase
    end

    // read data registered with ack, zero for unmapped offsets
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req_live && !ack_r) begin
            wb_dat_o <= {16'h0000, rd_word & rd_mask & {16{hit}}};
        end
    end

    // ==========================================================
    // checks
    a_unused_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_r && !wb_we_i |-> (wb_dat_o[31:16] == 16'h0000) &&
            ((wb_dat_o[15:0] & ~$past(rd_mask)) == 16'h0000))
        else $error("unimplemented bits read nonzero");

    a_stamp_field_wr: assert property (@(posedge clk_i) disable iff (rst_i)
        prio_wr[2] && wb_sel_i[1] |=>
            cfg_q[2][10:8] == $past(wb_dat_i[10:8]))
        else $error("timestamp field did not take write");

    a_serial6_fields: assert property (@(posedge clk_i) disable iff (rst_i)
        prio_wr[3] && wb_sel_i[1] |=>
            cfg_q[3][14:12] == $past(wb_dat_i[14:12]) &&
            cfg_q[3][10:8] == $past(wb_dat_i[10:8]))
        else $error("serial6 fields did not take write");

    a_testport_upper: assert property (@(posedge clk_i) disable iff (rst_i)
        prio_wr[4] && wb_sel_i[0] |=>
            cfg_q[4][15:7] == 9'h000 &&
            cfg_q[4][6:4] == $past(wb_dat_i[6:4]))
        else $error("test port register layout broken");

    a_serial6_err_low: assert property (@(posedge clk_i) disable iff (rst_i)
        prio_wr[4] && wb_sel_i[0] |=>
            cfg_q[4][3] == 1'b0 &&
            cfg_q[4][2:0] == $past(wb_dat_i[2:0]))
        else $error("serial6 error field layout broken");

    a_level_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 tst_word[11:8] == $past(cpu_level_i))
        else $error("reported level differs from cpu level");

    a_vector_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        cpu_ack_i && pending_r && !hold_r ##1 !hold_r |->
            shown_vec == $past(cpu_irq_vec_o))
        else $error("acked vector not captured");

    a_reset_level_four: assert property (@(posedge clk_i)
        $past(rst_i) |-> cfg_q[0] == 16'h0444 && cfg_q[4] == 16'h0044)
        else $error("priority fields not at level 4 after reset");

    a_ack_drops_req: assert property (@(posedge clk_i) disable iff (rst_i)
        cpu_ack_i |=> !cpu_irq_o)
        else $error("request still high after ack");

    a_test_read_only: assert property (@(posedge clk_i) disable iff (rst_i)
        tst_wr && !cpu_ack_i |=> ack_vec_r == $past(ack_vec_r))
        else $error("test write changed captured vector");
endmodule : ipt_regs
`default_nettype wire

/* verification/ipt_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// processor core stand-in: answers a presented request
module ipt_core_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // request from the controller
    input  wire logic       irq_i,
    // behaviour control from the bench
    input  wire logic       en_i,
    input  wire logic [3:0] dly_i,
    // acknowledge pulse to the controller
    output logic            ack_o
);
    logic [3:0] wait_r;

    // wait dly_i cycles on a standing request, then pulse ack once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o  <= 1'h0;
            wait_r <= 4'h0;
        end else begin
            ack_o <= 1'h0;
            if (en_i && irq_i && !ack_o) begin
                if (wait_r == dly_i) begin
                    ack_o  <= 1'h1;
                    wait_r <= 4'h0;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end else begin
                wait_r <= 4'h0;
            end
        end
    end
endmodule : ipt_core_model
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
// ============================================================
// self-checking bench for the priority and test registers
module tb_top;
    import ipt_pkg::*;
    localparam logic [15:0] PMSK [5] =
        '{16'h0777, 16'h0700, 16'h7770, 16'h7777, 16'h0077};
    localparam int S_REG [13] = '{0,0,0,1,2,2,2,3,3,3,3,4,4};
    localparam int S_LSB [13] = '{8,4,0,8,12,8,4,12,8,4,0,4,0};
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        wb_cyc, wb_stb, wb_we, wb_ack, cpu_ack, cpu_irq;
    logic        core_en, hold;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel, cpu_level, core_dly;
    logic [31:0] wb_wdat, wb_rdat, q;
    logic [12:0] src_req;
    logic [2:0]  irq_prio;
    logic [6:0]  irq_vec, last_vec;
    logic [15:0] mir [5];
    logic [15:0] rnd = 16'h0025;
    int          n_fail = 0, checked = 0, cyc_cnt = 0, r, t;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    ipt_regs ipt_regs_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .src_req_i(src_req), .cpu_level_i(cpu_level), .cpu_ack_i(cpu_ack),
        .cpu_irq_o(cpu_irq), .cpu_irq_prio_o(irq_prio),
        .cpu_irq_vec_o(irq_vec));
    ipt_core_model ipt_core_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .irq_i(cpu_irq), .en_i(core_en),
        .dly_i(core_dly), .ack_o(cpu_ack));

    // ============================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic results();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input int ra, input logic [3:0] sel,
                      input logic [15:0] d, output logic [31:0] rq);
        int w;
        @(posedge clk_i);
        wb_cyc  <= 1'h1;
        wb_stb  <= 1'h1;
        wb_we   <= we;
        wb_adr  <= 8'(ra * 4);
        wb_sel  <= sel;
        wb_wdat <= {16'h0000, d};
        w = 0;
        do begin
            @(posedge clk_i);
            w++;
        end while (wb_ack !== 1'h1 && w < 50);
        rq = wb_rdat;
        if (w >= 50) n_fail++;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we  <= 1'h0;
    endtask : wb

    task automatic rd(input int ra, output logic [31:0] rq);
        wb(1'h0, ra, 4'h3, 16'h0000, rq);
    endtask : rd

    // write and update the register mirror lane by lane
    task automatic wr(input int ra, input logic [3:0] sel,
                      input logic [15:0] d);
        logic [31:0] dq;
        wb(1'h1, ra, sel, d, dq);
        if (ra < 5) begin
            if (sel[0]) mir[ra][7:0] = d[7:0];
            if (sel[1]) mir[ra][15:8] = d[15:8];
            mir[ra] = mir[ra] & PMSK[ra];
        end else if (ra == 5 && sel[1]) begin
            hold = d[13];
        end
    endtask : wr

    // model: highest field wins, lowest index on a tie, 000 never
    task automatic chk_core();
        int idx, p, f;
        logic e;
        logic [31:0] tq;
        idx = 0;
        p = 0;
        for (int i = 0; i < 13; i++) begin
            f = int'((mir[S_REG[i]] >> S_LSB[i]) & 16'h0007);
            if (src_req[i] && f > p) begin
                idx = i;
                p = f;
            end
        end
        e = (p > int'(cpu_level));
        `CHK(cpu_irq, e)
        if (e) begin
            `CHK(irq_prio, 3'(p))
            `CHK(irq_vec, 7'(VEC_BASE + idx))
        end
        rd(5, tq);
        `CHK(tq[15], e)
        `CHK(tq[11:8], cpu_level)
        if (hold) begin
            `CHK(tq[6:0], (p > 0) ? 7'(VEC_BASE + idx) : 7'h00)
        end else begin
            `CHK(tq[6:0], last_vec)
        end
    endtask : chk_core

    // hang guard
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            n_fail++;
            results();
        end
    end

    // ============================================================
    // main sequence
    initial begin
        {wb_cyc, wb_stb, wb_we, core_en, hold} = 5'h00;
        {wb_adr, wb_sel, wb_wdat} = 44'h0;
        {src_req, cpu_level, core_dly, last_vec} = 28'h0;
        for (int i = 0; i < 5; i++) mir[i] = 16'h4444 & PMSK[i];
        tick(10);
        rst_i <= 1'h0;
        // reset values, then an unmapped word
        for (r = 0; r < 7; r++) begin
            rd(r, q);
            `CHK(q, {16'h0000, (r < 5) ? mir[r] : 16'h0000})
        end
        // all ones, then random data through random byte lanes
        for (r = 0; r < 5; r++) begin
            wr(r, 4'h3, 16'hFFFF);
            rd(r, q);
            `CHK(q, {16'h0000, PMSK[r]})
        end
        for (int n = 0; n < 10; n++) begin
            rnd = lfsr(rnd);
            r = int'(rnd[10:8]) % 5;
            wr(r, {2'h0, rnd[1:0]}, {rnd[7:0], rnd[15:8]});
            rd(r, q);
            `CHK(q[15:0], mir[r])
        end
        // only capture select takes a write in the test register
        cpu_level <= 4'hF;
        wr(5, 4'h3, 16'hFFFF);
        tick(2);
        rd(5, q);
        `CHK(q, 32'h0000_2F00)
        wr(5, 4'h3, 16'h0000);
        cpu_level <= 4'h0;
        // every code on the timestamp source alone
        for (r = 0; r < 5; r++) wr(r, 4'h3, 16'h0000);
        src_req <= 13'h0020;
        for (int k = 0; k < 8; k++) begin
            wr(2, 4'h3, 16'(k << 8));
            tick(4);
            chk_core();
        end
        // random fields, requests, levels and capture select
        for (int n = 0; n < 30; n++) begin
            rnd = lfsr(rnd);
            r = int'(rnd[15:13]) % 5;
            wr(r, 4'h3, {rnd[7:0], rnd[15:8]});
            wr(5, 4'h2, {2'h0, rnd[4], 13'h0000});
            rnd = lfsr(rnd);
            src_req <= rnd[12:0];
            cpu_level <= {1'h0, rnd[15:13]};
            tick(4);
            chk_core();
        end
        // core acknowledge drops the request and captures the vector
        wr(5, 4'h3, 16'h0000);
        for (r = 0; r < 5; r++) wr(r, 4'h3, 16'h0000);
        wr(2, 4'h3, 16'h0600);
        src_req <= 13'h0020;
        cpu_level <= 4'h0;
        tick(4);
        chk_core();
        core_dly <= 4'h2;
        core_en <= 1'h1;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (cpu_ack !== 1'h1 && t < 20);
        if (t >= 20) n_fail++;
        core_en <= 1'h0;
        src_req <= 13'h0000;
        last_vec = 7'(VEC_BASE + 5);
        @(posedge clk_i);
        `CHK(cpu_irq, 1'h0)
        tick(4);
        chk_core();
        results();
    end
endmodule : tb_top
`default_nettype wire
